// ==== ewpc_device.sv ====
/*
 EEPROM slave end: decodes memory-write and lock-flag commands on the link,
 keeps both soft lock flags and gates array writes, and times the internal
 write cycle. Assumes every link pin is asynchronous to core_clk and that
 SCL is slow enough for a two-stage synchroniser (at least 8 core cycles
 per SCL level). Array storage and memory reads live outside this block.
*/
// The strobed register port and the placing of the registers were left to the implementer.
`timescale 1ns/100ps
module ewpc_device #(
	parameter int WR_CYCLES = ewpc_pkg::WR_CYC
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// Link
	ewpc_if.dev link,
	// Array write port and status
	output logic mem_wr_en,
	output logic [7:0] mem_wr_addr,
	output logic [7:0] mem_wr_data,
	output logic write_busy,
	output logic permanent_lock_flag,
	output logic reversible_lock_flag
);
	typedef struct packed {
		logic [1:0] scl_sy;
		logic [1:0] sda_sy;
		logic [4:0] pin_s1;
		logic [4:0] pin_s2;
		logic scl_d;
		logic sda_d;
		ewpc_pkg::ewpc_dst_t st;
		logic [3:0] bits;
		logic [7:0] sh;
		logic ack_ph;
		logic ack_go;
		logic drv;
		ewpc_pkg::ewpc_op_t op;
		logic wp_blk;
		logic armed;
		logic [7:0] madr;
		ewpc_pkg::ewpc_busy_t busy;
		logic perm;
		logic rev;
		logic wr_en;
		logic [7:0] wr_addr;
		logic [7:0] wr_data;
	} ewpc_dev_st_t;

	ewpc_dev_st_t s_ff;
	ewpc_dev_st_t nxt_s;

	always_comb begin
		logic rise;
		logic fall;
		logic start;
		logic stop;
		logic hv;
		logic wp;
		logic busy;
		logic blocked;
		logic [2:0] pins;
		logic [7:0] b;
		rise = 1'b0;
		fall = 1'b0;
		start = 1'b0;
		stop = 1'b0;
		hv = 1'b0;
		wp = 1'b0;
		busy = 1'b0;
		blocked = 1'b0;
		pins = 3'h0;
		b = 8'h00;
		nxt_s = s_ff;
		nxt_s.scl_sy = {s_ff.scl_sy[0], link.scl};
		nxt_s.sda_sy = {s_ff.sda_sy[0], link.sda};
		nxt_s.pin_s1 = {link.overvoltage_level, link.wp, link.addr_select_2,
			link.addr_select_1, link.addr_select_0};
		nxt_s.pin_s2 = s_ff.pin_s1;
		nxt_s.scl_d = s_ff.scl_sy[1];
		nxt_s.sda_d = s_ff.sda_sy[1];
		nxt_s.wr_en = 1'b0;

		rise = s_ff.scl_sy[1] && !s_ff.scl_d;
		fall = !s_ff.scl_sy[1] && s_ff.scl_d;
		start = s_ff.scl_sy[1] && s_ff.scl_d && s_ff.sda_d && !s_ff.sda_sy[1];
		stop = s_ff.scl_sy[1] && s_ff.scl_d && !s_ff.sda_d && s_ff.sda_sy[1];
		hv = s_ff.pin_s2[4];
		wp = s_ff.pin_s2[3];
		pins = s_ff.pin_s2[2:0];
		busy = (s_ff.busy != '0);
		b = {s_ff.sh[6:0], s_ff.sda_sy[1]};
		if (busy) begin
			nxt_s.busy = s_ff.busy - 1'b1;
		end

		if (stop) begin
			// Commit only at STOP, so an aborted command leaves the flags alone
			if (s_ff.armed) begin
				nxt_s.busy = ewpc_pkg::ewpc_busy_t'(WR_CYCLES);
				unique case (s_ff.op)
					ewpc_pkg::OP_SET_PERM: nxt_s.perm = 1'b1;
					ewpc_pkg::OP_SET_REV: nxt_s.rev = 1'b1;
					ewpc_pkg::OP_CLR_REV: nxt_s.rev = 1'b0;
					default: ;
				endcase
			end
			nxt_s.st = ewpc_pkg::D_IDLE;
			nxt_s.drv = 1'b0;
			nxt_s.armed = 1'b0;
		end else if (start) begin
			nxt_s.st = ewpc_pkg::D_ADDR;
			nxt_s.bits = 4'h0;
			nxt_s.drv = 1'b0;
			nxt_s.armed = 1'b0;
			nxt_s.op = ewpc_pkg::OP_NONE;
		end else begin
			unique case (s_ff.st)
				ewpc_pkg::D_IDLE, ewpc_pkg::D_IGNORE: ;
				ewpc_pkg::D_ADDR, ewpc_pkg::D_BADR, ewpc_pkg::D_DATA: begin
					if (rise) begin
						nxt_s.sh = b;
						nxt_s.bits = s_ff.bits + 4'h1;
					end
					if (rise && s_ff.bits == ewpc_pkg::LAST_BIT) begin
						nxt_s.ack_ph = 1'b0;
						nxt_s.ack_go = 1'b0;
						if (s_ff.st == ewpc_pkg::D_ADDR) begin
							nxt_s.st = ewpc_pkg::D_ADDR_ACK;
							nxt_s.op = ewpc_pkg::OP_NONE;
							if (busy) begin
								nxt_s.ack_go = 1'b0;
							end else if (b[7:4] == ewpc_pkg::PRE_MEM) begin
								nxt_s.ack_go = (b[3:1] == ewpc_pkg::ewpc_pin_bits(pins, hv));
								nxt_s.op = ewpc_pkg::OP_MEM_WR;
							end else if (b[7:4] == ewpc_pkg::PRE_LOCK) begin
								if (hv) begin
									if (b[3:1] == ewpc_pkg::REV_SET_BITS
										&& pins[2:1] == ewpc_pkg::REV_SET_PINS) begin
										nxt_s.ack_go = !s_ff.perm && !s_ff.rev;
										nxt_s.op = ewpc_pkg::OP_SET_REV;
									end else if (b[3:1] == ewpc_pkg::REV_CLR_BITS
										&& pins[2:1] == ewpc_pkg::REV_CLR_PINS) begin
										nxt_s.ack_go = !s_ff.perm;
										nxt_s.op = ewpc_pkg::OP_CLR_REV;
									end
								end else if (b[3:1] == pins) begin
									nxt_s.ack_go = !s_ff.perm;
									nxt_s.op = ewpc_pkg::OP_SET_PERM;
								end
							end
							// A query reports the flag in this ack slot and moves nothing
							if (b[0]) begin
								nxt_s.op = ewpc_pkg::OP_NONE;
							end
						end else if (s_ff.st == ewpc_pkg::D_BADR) begin
							nxt_s.st = ewpc_pkg::D_BADR_ACK;
							nxt_s.madr = b;
							nxt_s.ack_go = 1'b1;
						end else begin
							nxt_s.st = ewpc_pkg::D_DATA_ACK;
							blocked = s_ff.wp_blk
								|| (s_ff.op == ewpc_pkg::OP_MEM_WR && (s_ff.perm || s_ff.rev)
								&& !s_ff.madr[ewpc_pkg::HALF_BIT]);
							nxt_s.ack_go = !blocked;
							if (!blocked) begin
								nxt_s.armed = 1'b1;
								if (s_ff.op == ewpc_pkg::OP_MEM_WR) begin
									nxt_s.wr_en = 1'b1;
									nxt_s.wr_addr = s_ff.madr;
									nxt_s.wr_data = b;
									// Page wrap: only the low nibble advances
									nxt_s.madr = {s_ff.madr[7:4], s_ff.madr[3:0] + 4'h1};
								end
							end
						end
					end
				end
				ewpc_pkg::D_ADDR_ACK, ewpc_pkg::D_BADR_ACK, ewpc_pkg::D_DATA_ACK: begin
					if (fall && !s_ff.ack_ph) begin
						nxt_s.drv = s_ff.ack_go;
						nxt_s.ack_ph = 1'b1;
					end else if (fall) begin
						nxt_s.drv = 1'b0;
						nxt_s.bits = 4'h0;
						nxt_s.st = ewpc_pkg::D_IGNORE;
						if (s_ff.st == ewpc_pkg::D_BADR_ACK) begin
							nxt_s.wp_blk = wp;
						end
						if (s_ff.ack_go && s_ff.op != ewpc_pkg::OP_NONE) begin
							unique case (s_ff.st)
								ewpc_pkg::D_ADDR_ACK: nxt_s.st = ewpc_pkg::D_BADR;
								ewpc_pkg::D_BADR_ACK: nxt_s.st = ewpc_pkg::D_DATA;
								default: begin
									if (s_ff.op == ewpc_pkg::OP_MEM_WR) begin
										nxt_s.st = ewpc_pkg::D_DATA;
									end
								end
							endcase
						end
					end
				end
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			s_ff <= '0;
			s_ff.scl_sy <= 2'h3;
			s_ff.sda_sy <= 2'h3;
			s_ff.scl_d <= 1'b1;
			s_ff.sda_d <= 1'b1;
			s_ff.st <= ewpc_pkg::D_IDLE;
			s_ff.op <= ewpc_pkg::OP_NONE;
			s_ff.perm <= ewpc_pkg::FLAG_RST;
			s_ff.rev <= ewpc_pkg::FLAG_RST;
		end else begin
			s_ff <= nxt_s;
		end
	end

	assign link.sda_dev_o = 1'b0;
	assign link.sda_dev_oe = s_ff.drv;
	assign mem_wr_en = s_ff.wr_en;
	assign mem_wr_addr = s_ff.wr_addr;
	assign mem_wr_data = s_ff.wr_data;
	assign write_busy = (s_ff.busy != '0);
	assign permanent_lock_flag = s_ff.perm;
	assign reversible_lock_flag = s_ff.rev;
endmodule

// ==== ewpc_pkg.sv ====
/*
 Shared constants, types and decode helpers for the EEPROM write-protect
 controller: the slave end (device) and the bus master end (host).
 Assumes a 100 MHz core clock on both ends and an I2C link that the host
 clocks by dividing its own core clock.
*/
package ewpc_pkg;
	localparam int CLK_PERIOD_NS = 10;
	localparam int SCL_PERIOD_NS = 2000;
	localparam int SCL_QTR_CYC = SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);
	localparam int BIT_CYC = 4 * SCL_QTR_CYC;
	localparam int WR_TIME_NS = 5000000;
	localparam int WR_CYC = WR_TIME_NS / CLK_PERIOD_NS;
	localparam int BUSY_W = 20;
	localparam int QTR_W = 8;
	localparam int HALF_BIT = 7;
	localparam logic [3:0] PRE_MEM = 4'hA;
	localparam logic [3:0] PRE_LOCK = 4'h6;
	localparam logic [2:0] REV_SET_BITS = 3'h1;
	localparam logic [2:0] REV_CLR_BITS = 3'h3;
	localparam logic [1:0] REV_SET_PINS = 2'h0;
	localparam logic [1:0] REV_CLR_PINS = 2'h1;
	localparam logic [7:0] DUMMY_BYTE = 8'h00;
	localparam logic FLAG_RST = 1'h0;
	localparam logic [3:0] LAST_BIT = 4'h7;
	localparam logic [3:0] ACK_BIT = 4'h8;

	typedef logic [BUSY_W-1:0] ewpc_busy_t;
	typedef logic [QTR_W-1:0] ewpc_qtr_t;

	typedef enum logic [2:0] {
		OP_NONE = 3'h0,
		OP_MEM_WR = 3'h1,
		OP_SET_PERM = 3'h2,
		OP_SET_REV = 3'h3,
		OP_CLR_REV = 3'h4
	} ewpc_op_t;

	typedef enum logic [2:0] {
		D_IDLE = 3'h0,
		D_ADDR = 3'h1,
		D_ADDR_ACK = 3'h2,
		D_BADR = 3'h3,
		D_BADR_ACK = 3'h4,
		D_DATA = 3'h5,
		D_DATA_ACK = 3'h6,
		D_IGNORE = 3'h7
	} ewpc_dst_t;

	typedef enum logic [2:0] {
		H_IDLE = 3'h0,
		H_SETUP = 3'h1,
		H_START = 3'h2,
		H_BIT = 3'h3,
		H_STOP = 3'h4,
		H_HOLD = 3'h5
	} ewpc_hst_t;

	// Address bits 3..1 as the pins present them; overvoltage reads as one
	function automatic logic [2:0] ewpc_pin_bits(input logic [2:0] pins, input logic hv);
		ewpc_pin_bits = {pins[2:1], pins[0] | hv};
	endfunction
endpackage

// ==== ewpc_if.sv ====
/*
 Link between the bus master end and the EEPROM slave end: SCL, open-drain
 SDA and the strap pins. Assumes a pull-up on SDA: the line is low only
 while an end enables its driver with a low output.
*/
`timescale 1ns/100ps
interface ewpc_if;
	logic scl;
	logic sda;
	logic sda_host_o;
	logic sda_host_oe;
	logic sda_dev_o;
	logic sda_dev_oe;
	logic wp;
	logic addr_select_0;
	logic addr_select_1;
	logic addr_select_2;
	logic overvoltage_level;

	// Wired-AND of both open-drain drivers with the pull-up
	assign sda = !((sda_host_oe && !sda_host_o) || (sda_dev_oe && !sda_dev_o));

	modport host (
		output scl,
		output sda_host_o,
		output sda_host_oe,
		output wp,
		output addr_select_0,
		output addr_select_1,
		output addr_select_2,
		output overvoltage_level,
		input sda
	);

	modport dev (
		input scl,
		input sda,
		input wp,
		input addr_select_0,
		input addr_select_1,
		input addr_select_2,
		input overvoltage_level,
		output sda_dev_o,
		output sda_dev_oe
	);
endinterface

// ==== ewpc_host.sv ====
/*
 Bus master end: runs one write or lock command per request, makes SCL by
 dividing core_clk, drives the strap pins for the whole command and reports
 the three acknowledge slots. Assumes a pull-up on SDA and that the slave
 never stretches SCL.
*/
`timescale 1ns/100ps
module ewpc_host (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// Link
	ewpc_if.host link,
	// Request
	input wire logic cmd_valid,
	input wire logic cmd_lock,
	input wire logic cmd_read,
	input wire logic [2:0] cmd_pins,
	input wire logic cmd_hv,
	input wire logic [7:0] cmd_addr,
	input wire logic [7:0] cmd_data,
	input wire logic wp_level,
	output logic cmd_ready,
	// Answer
	output logic done,
	output logic [2:0] acks
);
	typedef struct packed {
		logic [1:0] sda_sy;
		ewpc_pkg::ewpc_qtr_t q;
		logic [1:0] ph;
		ewpc_pkg::ewpc_hst_t st;
		logic [1:0] byte_i;
		logic [3:0] bit_i;
		logic [7:0] tx;
		logic [7:0] b1;
		logic [7:0] b2;
		logic rd;
		logic scl;
		logic drv;
		logic [2:0] pins;
		logic hv;
		logic [2:0] acks;
		logic done;
	} ewpc_host_st_t;

	ewpc_host_st_t s_ff;
	ewpc_host_st_t nxt_s;

	always_comb begin
		logic tick;
		tick = (s_ff.q == '0);
		nxt_s = s_ff;
		nxt_s.sda_sy = {s_ff.sda_sy[0], link.sda};
		nxt_s.done = 1'b0;
		nxt_s.q = tick ? ewpc_pkg::ewpc_qtr_t'(ewpc_pkg::SCL_QTR_CYC - 1) : s_ff.q - 1'b1;
		if (tick) begin
			nxt_s.ph = s_ff.ph + 2'h1;
		end
		unique case (s_ff.st)
			ewpc_pkg::H_IDLE: begin
				nxt_s.ph = 2'h0;
				if (cmd_valid) begin
					nxt_s.st = ewpc_pkg::H_SETUP;
					nxt_s.pins = cmd_pins;
					nxt_s.hv = cmd_hv;
					nxt_s.rd = cmd_read;
					nxt_s.tx = {cmd_lock ? ewpc_pkg::PRE_LOCK : ewpc_pkg::PRE_MEM,
						ewpc_pkg::ewpc_pin_bits(cmd_pins, cmd_hv), cmd_read};
					nxt_s.b1 = cmd_lock ? ewpc_pkg::DUMMY_BYTE : cmd_addr;
					nxt_s.b2 = cmd_lock ? ewpc_pkg::DUMMY_BYTE : cmd_data;
					nxt_s.acks = 3'h0;
					nxt_s.q = ewpc_pkg::ewpc_qtr_t'(ewpc_pkg::SCL_QTR_CYC - 1);
				end
			end
			ewpc_pkg::H_SETUP: begin
				// Pins settle two full quarters before START
				if (tick) begin
					nxt_s.st = ewpc_pkg::H_START;
					nxt_s.ph = 2'h0;
				end
			end
			ewpc_pkg::H_START: begin
				if (tick && s_ff.ph == 2'h0) begin
					nxt_s.drv = 1'b1;
				end else if (tick && s_ff.ph == 2'h1) begin
					nxt_s.scl = 1'b0;
					nxt_s.st = ewpc_pkg::H_BIT;
					nxt_s.ph = 2'h0;
					nxt_s.byte_i = 2'h0;
					nxt_s.bit_i = 4'h0;
				end
			end
			ewpc_pkg::H_BIT: begin
				if (tick) begin
					unique case (s_ff.ph)
						2'h0: nxt_s.drv = (s_ff.bit_i != ewpc_pkg::ACK_BIT) && !s_ff.tx[7];
						2'h1: nxt_s.scl = 1'b1;
						2'h2: begin
							if (s_ff.bit_i == ewpc_pkg::ACK_BIT) begin
								nxt_s.acks[s_ff.byte_i] = !s_ff.sda_sy[1];
							end
						end
						2'h3: begin
							nxt_s.scl = 1'b0;
							nxt_s.bit_i = s_ff.bit_i + 4'h1;
							nxt_s.tx = {s_ff.tx[6:0], 1'b0};
							if (s_ff.bit_i == ewpc_pkg::ACK_BIT) begin
								nxt_s.bit_i = 4'h0;
								nxt_s.byte_i = s_ff.byte_i + 2'h1;
								nxt_s.tx = (s_ff.byte_i == 2'h0) ? s_ff.b1 : s_ff.b2;
								if (s_ff.rd || !s_ff.acks[s_ff.byte_i] || s_ff.byte_i == 2'h2) begin
									nxt_s.st = ewpc_pkg::H_STOP;
								end
							end
						end
					endcase
				end
			end
			ewpc_pkg::H_STOP: begin
				if (tick) begin
					unique case (s_ff.ph)
						2'h0: nxt_s.drv = 1'b1;
						2'h1: nxt_s.scl = 1'b1;
						2'h2: nxt_s.drv = 1'b0;
						2'h3: nxt_s.st = ewpc_pkg::H_HOLD;
					endcase
				end
			end
			ewpc_pkg::H_HOLD: begin
				// Overvoltage released only two quarters after STOP
				if (tick) begin
					nxt_s.hv = 1'b0;
					nxt_s.done = 1'b1;
					nxt_s.st = ewpc_pkg::H_IDLE;
				end
			end
			default: nxt_s.st = ewpc_pkg::H_IDLE;
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			s_ff <= '0;
			s_ff.sda_sy <= 2'h3;
			s_ff.scl <= 1'b1;
			s_ff.st <= ewpc_pkg::H_IDLE;
		end else begin
			s_ff <= nxt_s;
		end
	end

	assign cmd_ready = (s_ff.st == ewpc_pkg::H_IDLE);
	assign done = s_ff.done;
	assign acks = s_ff.acks;
	assign link.scl = s_ff.scl;
	assign link.sda_host_o = 1'b0;
	assign link.sda_host_oe = s_ff.drv;
	assign link.wp = wp_level;
	assign link.addr_select_0 = s_ff.pins[0];
	assign link.addr_select_1 = s_ff.pins[1];
	assign link.addr_select_2 = s_ff.pins[2];
	assign link.overvoltage_level = s_ff.hv;
endmodule

// ==== ewpc_properties.sv ====
/*
 Concurrent checks on the link between the bus master end and the slave end.
 Assumes it is instantiated beside the interface and sees its signals plus
 the core clock and synchronous active-low reset of both ends.
*/
`timescale 1ns/100ps
module ewpc_properties (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// Link
	input wire logic scl,
	input wire logic sda,
	input wire logic sda_host_oe,
	input wire logic sda_dev_oe,
	input wire logic addr_select_0,
	input wire logic addr_select_1,
	input wire logic addr_select_2,
	input wire logic overvoltage_level
);
	// Length of the current slave drive; one bit time is four divider quarters
	logic [10:0] oe_cnt_ff;

	always_ff @(posedge core_clk) begin
		if (!rst_n || !sda_dev_oe) begin
			oe_cnt_ff <= 11'h000;
		end else if (oe_cnt_ff != 11'h7FF) begin
			oe_cnt_ff <= oe_cnt_ff + 11'h001;
		end
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	property p_hv_rise_idle;
		$rose(overvoltage_level) |-> scl && sda;
	endproperty
	a_hv_rise_idle: assert property (p_hv_rise_idle) else $error("overvoltage raised inside a frame");

	property p_hv_fall_idle;
		$fell(overvoltage_level) |-> scl && sda;
	endproperty
	a_hv_fall_idle: assert property (p_hv_fall_idle) else $error("overvoltage dropped inside a frame");

	// Overvoltage must not outlive the command by much
	property p_hv_after_stop;
		$rose(sda) && scl && overvoltage_level |-> ##[1:600] !overvoltage_level;
	endproperty
	a_hv_after_stop: assert property (p_hv_after_stop) else $error("overvoltage held after stop");

	property p_straps_idle;
		!$stable({addr_select_2, addr_select_1, addr_select_0}) |-> scl && sda;
	endproperty
	a_straps_idle: assert property (p_straps_idle) else $error("strap pins moved inside a frame");

	property p_dev_oe_scl_low;
		$changed(sda_dev_oe) |-> !scl;
	endproperty
	a_dev_oe_scl_low: assert property (p_dev_oe_scl_low) else $error("slave drive changed with clock high");

	// No data byte is ever served, so the slave drives one acknowledge slot at most
	property p_dev_oe_short;
		sda_dev_oe |-> oe_cnt_ff < 11'(ewpc_pkg::BIT_CYC + 8);
	endproperty
	a_dev_oe_short: assert property (p_dev_oe_short) else $error("slave drove longer than one slot");

	property p_start_scl_fall;
		$fell(sda) && scl |-> ##[1:600] !scl;
	endproperty
	a_start_scl_fall: assert property (p_start_scl_fall) else $error("clock did not fall after start");

	property p_sda_stable;
		scl && $past(scl) && $changed(sda) |-> $changed(sda_host_oe);
	endproperty
	a_sda_stable: assert property (p_sda_stable) else $error("data moved with clock high");

	// The slave samples through two flops, so each clock high level (the only level checked here) must last
	property p_scl_high_min;
		$rose(scl) |=> scl [*8];
	endproperty
	a_scl_high_min: assert property (p_scl_high_min) else $error("clock high level too short");

	c_hv_frame: cover property ($fell(sda) && scl && overvoltage_level);
	c_dev_ack: cover property (sda_dev_oe && scl);
	c_plain_frame: cover property ($fell(sda) && scl && !overvoltage_level);
endmodule

// ==== ewpc_tb.sv ====
/*
 Self-checking bench: master end and slave end joined by the interface,
 commands issued through the master's request port and results read from
 the acknowledge report, the slave's flags and its array write port.
 Assumes a 100 MHz core clock and a shortened write cycle.
*/
`timescale 1ns/100ps
module tb;
	localparam int BUSY_CYC = 3000;
	logic core_clk;
	logic rst_n;
	logic cmd_valid, cmd_lock, cmd_read, cmd_hv, wp_level;
	logic [2:0] cmd_pins;
	logic [7:0] cmd_addr, cmd_data;
	logic cmd_ready, done, mem_wr_en, write_busy, permanent_lock_flag, reversible_lock_flag;
	logic [2:0] acks;
	logic [7:0] mem_wr_addr, mem_wr_data, sb;
	logic [15:0] wr_seen;
	int n_errors = 0;
	int compares = 0;
	int n_wr = 0;
	int bc = 8;

	ewpc_if ewpc_if_i();
	ewpc_host ewpc_host_i(.core_clk(core_clk), .rst_n(rst_n), .link(ewpc_if_i.host),
		.cmd_valid(cmd_valid), .cmd_lock(cmd_lock), .cmd_read(cmd_read), .cmd_pins(cmd_pins),
		.cmd_hv(cmd_hv), .cmd_addr(cmd_addr), .cmd_data(cmd_data), .wp_level(wp_level),
		.cmd_ready(cmd_ready), .done(done), .acks(acks));
	ewpc_device #(.WR_CYCLES(BUSY_CYC)) ewpc_device_i(.core_clk(core_clk), .rst_n(rst_n),
		.link(ewpc_if_i.dev), .mem_wr_en(mem_wr_en), .mem_wr_addr(mem_wr_addr),
		.mem_wr_data(mem_wr_data), .write_busy(write_busy),
		.permanent_lock_flag(permanent_lock_flag), .reversible_lock_flag(reversible_lock_flag));
	ewpc_properties ewpc_properties_i(.core_clk(core_clk), .rst_n(rst_n), .scl(ewpc_if_i.scl),
		.sda(ewpc_if_i.sda), .sda_host_oe(ewpc_if_i.sda_host_oe),
		.sda_dev_oe(ewpc_if_i.sda_dev_oe), .addr_select_0(ewpc_if_i.addr_select_0),
		.addr_select_1(ewpc_if_i.addr_select_1), .addr_select_2(ewpc_if_i.addr_select_2),
		.overvoltage_level(ewpc_if_i.overvoltage_level));

	initial begin
		core_clk = 1'h0;
		forever #5 core_clk = ~core_clk;
	end

	// Capture the first byte after each start, as the slave sees it
	always @(posedge ewpc_if_i.scl) if (bc < 8) begin
		sb = {sb[6:0], ewpc_if_i.sda};
		bc++;
	end
	always @(negedge ewpc_if_i.sda) if (ewpc_if_i.scl === 1'h1) bc = 0;
	always @(posedge core_clk) if (mem_wr_en === 1'h1) begin
		n_wr++;
		wr_seen = {mem_wr_addr, mem_wr_data};
	end

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			n_errors++;
			$display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
		end
	endtask

	task automatic give_verdict();
		$display("compares %0d, n_errors %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// One command through the master; checks the slave byte on the wire and the report
	task automatic run_cmd(input logic lock, input logic rd, input logic [2:0] pins,
		input logic hv, input logic [7:0] addr, input logic [7:0] data, input logic wp,
		input logic [7:0] exp_sb, input logic [2:0] exp_acks);
		int n;
		@(posedge core_clk);
		{cmd_lock, cmd_read, cmd_pins, cmd_hv, cmd_addr, cmd_data} <= {lock, rd, pins, hv, addr, data};
		wp_level <= wp;
		cmd_valid <= 1'h1;
		@(posedge core_clk);
		cmd_valid <= 1'h0;
		n = 0;
		while (done !== 1'h1 && n < 8000) begin
			@(negedge core_clk);
			n++;
		end
		check({15'h0000, done}, 16'h0001);
		check({8'h00, sb}, {8'h00, exp_sb});
		check({13'h0000, acks}, {13'h0000, exp_acks});
		check({14'h0000, ewpc_if_i.scl, ewpc_if_i.sda}, 16'h0003);
	endtask

	task automatic wait_idle();
		int n;
		n = 0;
		while (write_busy !== 1'h0 && n < 20000) begin
			@(negedge core_clk);
			n++;
		end
		check({15'h0000, write_busy}, 16'h0000);
	endtask

	initial begin
		repeat (90000) @(posedge core_clk);
		n_errors++;
		give_verdict();
	end

	initial begin
		rst_n = 1'h0;
		{cmd_valid, cmd_lock, cmd_read, cmd_hv, wp_level} = 5'h00;
		{cmd_pins, cmd_addr, cmd_data} = 19'h00000;
		repeat (5) @(posedge core_clk);
		rst_n <= 1'h1;
		// Query of a clear permanent flag at ordinary levels acknowledges
		run_cmd(1'h1, 1'h1, 3'h5, 1'h0, 8'h00, 8'h00, 1'h0, 8'h6B, 3'h1);
		// Reversible set: overvoltage on select 0 reads as one
		run_cmd(1'h1, 1'h0, 3'h0, 1'h1, 8'h00, 8'h00, 1'h0, 8'h62, 3'h7);
		check({15'h0000, write_busy}, 16'h0001);
		check({14'h0000, permanent_lock_flag, reversible_lock_flag}, 16'h0001);
		// Address refused while the write cycle runs, although the flag is clear
		run_cmd(1'h1, 1'h1, 3'h0, 1'h0, 8'h00, 8'h00, 1'h0, 8'h61, 3'h0);
		wait_idle();
		run_cmd(1'h1, 1'h1, 3'h0, 1'h1, 8'h00, 8'h00, 1'h0, 8'h63, 3'h0);
		// Setting a reversible flag that is already set is refused
		run_cmd(1'h1, 1'h0, 3'h0, 1'h1, 8'h00, 8'h00, 1'h0, 8'h62, 3'h0);
		// Lower half refused at the data byte, upper half written
		run_cmd(1'h0, 1'h0, 3'h0, 1'h0, 8'h05, 8'h3C, 1'h0, 8'hA0, 3'h3);
		check(16'(n_wr), 16'h0000);
		run_cmd(1'h0, 1'h0, 3'h0, 1'h0, 8'h85, 8'hC3, 1'h0, 8'hA0, 3'h7);
		check(16'(n_wr), 16'h0001);
		check(wr_seen, 16'h85C3);
		wait_idle();
		// Protect pin high: clear is taken up to the data byte, then refused
		run_cmd(1'h1, 1'h0, 3'h2, 1'h1, 8'h00, 8'h00, 1'h1, 8'h66, 3'h3);
		check({14'h0000, permanent_lock_flag, reversible_lock_flag}, 16'h0001);
		check({15'h0000, write_busy}, 16'h0000);
		// Accepted clear with protect low drops the reversible flag
		run_cmd(1'h1, 1'h0, 3'h2, 1'h1, 8'h00, 8'h00, 1'h0, 8'h66, 3'h7);
		check({14'h0000, permanent_lock_flag, reversible_lock_flag}, 16'h0000);
		wait_idle();
		// Permanent set at ordinary levels, any strap pattern
		run_cmd(1'h1, 1'h0, 3'h6, 1'h0, 8'h00, 8'h00, 1'h0, 8'h6C, 3'h7);
		check({14'h0000, permanent_lock_flag, reversible_lock_flag}, 16'h0002);
		wait_idle();
		// Once permanent, queries report set and the clear is refused
		run_cmd(1'h1, 1'h1, 3'h6, 1'h0, 8'h00, 8'h00, 1'h0, 8'h6D, 3'h0);
		run_cmd(1'h1, 1'h0, 3'h2, 1'h1, 8'h00, 8'h00, 1'h0, 8'h66, 3'h0);
		check({14'h0000, permanent_lock_flag, reversible_lock_flag}, 16'h0002);
		give_verdict();
	end
endmodule
